// *** hw/dds_defs.svh ***
/*
 * register offsets, field positions, reset values and steps for the
 * descriptor-pointer and block-setup register block.
 * assumes: included by the dds_top module of this block only.
 */
`ifndef DDS_DEFS_SVH
`define DDS_DEFS_SVH

`define DDS_OFF_DPTR_LO     8'h78
`define DDS_OFF_DPTR_HI     8'h7C
`define DDS_OFF_BSIZE       8'h80
`define DDS_OFF_CTRL        8'h90
`define DDS_OFF_STAT        8'h94
`define DDS_OFF_SADDR       8'h98

`define DDS_CTRL_ADDR64     0
`define DDS_CTRL_DMA_USE    1
`define DDS_CTRL_DATA_PHASE 2
`define DDS_CTRL_SGL_GO     4

`define DDS_STAT_CHAIN_BUSY 0
`define DDS_STAT_SGL_RUN    1
`define DDS_STAT_SGL_PAUSE  2
`define DDS_STAT_PAGE_EV    3
`define DDS_STAT_DONE_EV    4

`define DDS_BSIZE_LSB       0
`define DDS_BSIZE_MSB       11
`define DDS_PAGE_LSB        12
`define DDS_PAGE_MSB        14

`define DDS_BSIZE_RST       16'h0000
`define DDS_DPTR_RST        64'h0000_0000_0000_0000
`define DDS_SADDR_RST       32'h0000_0000
`define DDS_STEP32          64'h0000_0000_0000_0004
`define DDS_STEP64          64'h0000_0000_0000_0008
`define DDS_BEAT_BYTES      12'h004
`define DDS_BEAT_ADDR       32'h0000_0004
`define DDS_SGL_CAP         1'b1

`endif

// *** hw/dds_pkg.sv ***
/*
 * types of the descriptor-pointer and block-setup block.
 * assumes: constants come from dds_defs.svh.
 */
package dds_pkg;

    typedef enum logic [0:0] {CH_IDLE, CH_FETCH} dds_chain_e;
    typedef enum logic [1:0] {SD_IDLE, SD_RUN, SD_PAUSE} dds_single_e;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
        logic [3:0]  pstrb;
    } dds_apb_req_s;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } dds_apb_rsp_s;

    typedef struct packed {
        logic        req;
        logic [63:0] addr;
    } dds_fetch_s;

    typedef struct packed {
        logic        req;
        logic [31:0] addr;
    } dds_beat_s;

    typedef struct packed {
        dds_apb_rsp_s rsp;
        logic [63:0]  dptr;
        logic [15:0]  bsize;
        logic         addr64;
        logic         dma_use;
        logic         data_phase;
        logic [31:0]  saddr;
        logic [11:0]  remain;
        dds_chain_e   ch;
        dds_single_e  sd;
        logic         page_ev;
        logic         done_ev;
        dds_fetch_s   fetch;
        logic         beat_req;
    } dds_state_s;

endpackage

// *** hw/dds_page_watch.sv ***
/*
 * page-boundary detector for single-address dma: flags a carry out of
 * the address bit chosen by the 3-bit page code (4K up to 512K).
 * assumes: combinational, fed from registered addresses of one clock.
 */
`timescale 1ns/1ps
module dds_page_watch
(
    input  wire logic [2:0]  sel,
    input  wire logic [31:0] cur_addr,
    input  wire logic [31:0] nxt_addr,
    output logic             crossed
);
    logic [7:0] hit;

    // code i watches carry out of A(11+i): upper bits change
    genvar i;
    generate
        for (i = 0; i < 8; i++)
        begin : g_page
            assign hit[i] = (cur_addr[31:12+i] != nxt_addr[31:12+i]);
        end
    endgenerate

    assign crossed = hit[sel];
endmodule

// *** hw/dds_top.sv ***
/*
 * descriptor-list pointer and packet block setup, with the descriptor
 * chain fetch engine and the single-address dma beat engine they steer.
 * assumes: apb4 master on pclk; memory ports answer with one-cycle acks
 * on the same clock.
 */
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`include "dds_defs.svh"

module dds_top
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire dds_pkg::dds_apb_req_s apb_req,
    output dds_pkg::dds_apb_rsp_s      apb_rsp,
    output dds_pkg::dds_fetch_s        fetch,
    input  wire logic                  fetch_ack,
    input  wire logic                  fetch_last,
    output dds_pkg::dds_beat_s         beat,
    input  wire logic                  beat_ack,
    output logic                       chain_busy,
    output logic                       page_event,
    output logic                       done_event
);
    import dds_pkg::*;

    dds_state_s s_r;
    dds_state_s s_nxt;
    logic       crossed;
    logic       acc_first;
    logic       acc_done;
    logic       wr;
    logic [31:0] beat_nxt;

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == `DDS_OFF_DPTR_LO) || (a == `DDS_OFF_DPTR_HI) || (a == `DDS_OFF_BSIZE) ||
                    (a == `DDS_OFF_CTRL) || (a == `DDS_OFF_STAT) || (a == `DDS_OFF_SADDR);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] st);
        integer k;
        merge = old;
        for (k = 0; k < 4; k++)
        begin
            if (st[k])
            begin
                merge[8*k +: 8] = d[8*k +: 8];
            end
        end
    endfunction

    // masked fetch address; 32-bit mode uses the lower half only
    function automatic logic [63:0] fetch_addr(input logic [63:0] p, input logic m64);
        if (m64)
        begin
            fetch_addr = {p[63:3], 3'b000};
        end
        else
        begin
            fetch_addr = {32'h0000_0000, p[31:2], 2'b00};
        end
    endfunction

    assign acc_first = apb_req.psel & apb_req.penable & ~s_r.rsp.pready;
    assign acc_done  = apb_req.psel & apb_req.penable & s_r.rsp.pready;
    assign wr        = acc_done & apb_req.pwrite & is_mapped(apb_req.paddr);
    assign beat_nxt  = s_r.saddr + `DDS_BEAT_ADDR;

    dds_page_watch u_page
    (
        .sel      (s_r.bsize[`DDS_PAGE_MSB:`DDS_PAGE_LSB]),
        .cur_addr (s_r.saddr),
        .nxt_addr (beat_nxt),
        .crossed  (crossed)
    );

    always_comb
    begin
        logic        start;
        logic        go;
        logic        sa_wr;
        logic [31:0] rd;
        logic [31:0] w;
        start = 1'b0;
        go    = 1'b0;
        sa_wr = 1'b0;
        rd    = 32'h0000_0000;
        w     = 32'h0000_0000;
        s_nxt = s_r;

        // read data latched in the first access cycle, shown with pready
        case (apb_req.paddr)
            `DDS_OFF_DPTR_LO: rd = s_r.dptr[31:0];
            `DDS_OFF_DPTR_HI: rd = s_r.dptr[63:32];
            `DDS_OFF_BSIZE:   rd = {16'h0000, s_r.bsize};
            `DDS_OFF_CTRL:    rd = {29'h0000_0000, s_r.data_phase, s_r.dma_use, s_r.addr64};
            `DDS_OFF_STAT:    rd = {27'h000_0000, s_r.done_ev, s_r.page_ev, (s_r.sd == SD_PAUSE),
                                    (s_r.sd == SD_RUN), (s_r.ch == CH_FETCH)};
            `DDS_OFF_SADDR:   rd = s_r.saddr;
            default:          rd = 32'h0000_0000;
        endcase
        s_nxt.rsp.pready  = acc_first;
        s_nxt.rsp.prdata  = (acc_first && !apb_req.pwrite) ? rd : 32'h0000_0000;
        s_nxt.rsp.pslverr = acc_first & ~is_mapped(apb_req.paddr);

        if (wr)
        begin
            case (apb_req.paddr)
                `DDS_OFF_DPTR_LO:
                begin
                    // pointer frozen while the chain engine owns it
                    if (s_r.ch == CH_IDLE)
                    begin
                        s_nxt.dptr[31:0] = merge(s_r.dptr[31:0], apb_req.pwdata, apb_req.pstrb);
                        start = apb_req.pstrb[3] & ~s_r.addr64;
                    end
                end
                `DDS_OFF_DPTR_HI:
                begin
                    if (s_r.ch == CH_IDLE)
                    begin
                        s_nxt.dptr[63:32] = merge(s_r.dptr[63:32], apb_req.pwdata, apb_req.pstrb);
                        start = apb_req.pstrb[3] & s_r.addr64;
                    end
                end
                `DDS_OFF_BSIZE:
                begin
                    w = merge({16'h0000, s_r.bsize}, apb_req.pwdata, apb_req.pstrb);
                    s_nxt.bsize[`DDS_BSIZE_MSB:`DDS_BSIZE_LSB] = w[`DDS_BSIZE_MSB:`DDS_BSIZE_LSB];
                    // page field exists only with the capability strap
                    s_nxt.bsize[`DDS_PAGE_MSB:`DDS_PAGE_LSB] =
                        `DDS_SGL_CAP ? w[`DDS_PAGE_MSB:`DDS_PAGE_LSB] : 3'b000;
                end
                `DDS_OFF_CTRL:
                begin
                    if (apb_req.pstrb[0])
                    begin
                        s_nxt.addr64     = apb_req.pwdata[`DDS_CTRL_ADDR64];
                        s_nxt.dma_use    = apb_req.pwdata[`DDS_CTRL_DMA_USE];
                        s_nxt.data_phase = apb_req.pwdata[`DDS_CTRL_DATA_PHASE];
                        go               = apb_req.pwdata[`DDS_CTRL_SGL_GO];
                    end
                end
                `DDS_OFF_STAT:
                begin
                    if (apb_req.pstrb[0])
                    begin
                        if (apb_req.pwdata[`DDS_STAT_PAGE_EV])
                        begin
                            s_nxt.page_ev = 1'b0;
                        end
                        if (apb_req.pwdata[`DDS_STAT_DONE_EV])
                        begin
                            s_nxt.done_ev = 1'b0;
                        end
                    end
                end
                `DDS_OFF_SADDR:
                begin
                    s_nxt.saddr = merge(s_r.saddr, apb_req.pwdata, apb_req.pstrb);
                    sa_wr = 1'b1;
                end
                default:
                begin
                    s_nxt.dptr = s_r.dptr;
                end
            endcase
        end

        // descriptor chain engine; it never looks at the page field
        case (s_r.ch)
            CH_IDLE:
            begin
                if (start)
                begin
                    s_nxt.ch          = CH_FETCH;
                    s_nxt.fetch.req   = 1'b1;
                    s_nxt.fetch.addr  = fetch_addr(s_nxt.dptr, s_r.addr64);
                end
            end
            CH_FETCH:
            begin
                if (fetch_ack)
                begin
                    s_nxt.dptr = s_r.dptr + (s_r.addr64 ? `DDS_STEP64 : `DDS_STEP32);
                    s_nxt.fetch.addr = fetch_addr(s_nxt.dptr, s_r.addr64);
                    if (fetch_last)
                    begin
                        s_nxt.ch        = CH_IDLE;
                        s_nxt.fetch.req = 1'b0;
                    end
                end
            end
            default:
            begin
                s_nxt.ch        = CH_IDLE;
                s_nxt.fetch.req = 1'b0;
            end
        endcase

        // single-address dma; event sets come last so a set beats a clear
        case (s_r.sd)
            SD_IDLE:
            begin
                if (go && s_r.dma_use)
                begin
                    // size counts only with a data phase; zero moves nothing
                    if (s_r.data_phase && (s_r.bsize[`DDS_BSIZE_MSB:`DDS_BSIZE_LSB] != 12'h000))
                    begin
                        s_nxt.remain   = s_r.bsize[`DDS_BSIZE_MSB:`DDS_BSIZE_LSB];
                        s_nxt.sd       = SD_RUN;
                        s_nxt.beat_req = 1'b1;
                    end
                    else
                    begin
                        s_nxt.remain  = 12'h000;
                        s_nxt.done_ev = 1'b1;
                    end
                end
            end
            SD_RUN:
            begin
                if (beat_ack)
                begin
                    s_nxt.saddr  = beat_nxt;
                    s_nxt.remain = (s_r.remain > `DDS_BEAT_BYTES) ? s_r.remain - `DDS_BEAT_BYTES : 12'h000;
                    if (s_r.remain <= `DDS_BEAT_BYTES)
                    begin
                        // last beat: done only, never a page event after it
                        s_nxt.sd       = SD_IDLE;
                        s_nxt.beat_req = 1'b0;
                        s_nxt.done_ev  = 1'b1;
                    end
                    else if (crossed && `DDS_SGL_CAP && s_r.dma_use)
                    begin
                        s_nxt.sd       = SD_PAUSE;
                        s_nxt.beat_req = 1'b0;
                        s_nxt.page_ev  = 1'b1;
                    end
                end
            end
            SD_PAUSE:
            begin
                if (sa_wr)
                begin
                    s_nxt.sd       = SD_RUN;
                    s_nxt.beat_req = 1'b1;
                end
            end
            default:
            begin
                s_nxt.sd       = SD_IDLE;
                s_nxt.beat_req = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_r            <= '0;
            s_r.dptr       <= `DDS_DPTR_RST;
            s_r.bsize      <= `DDS_BSIZE_RST;
            s_r.saddr      <= `DDS_SADDR_RST;
            s_r.ch         <= CH_IDLE;
            s_r.sd         <= SD_IDLE;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign apb_rsp    = s_r.rsp;
    assign fetch      = s_r.fetch;
    assign beat.req   = s_r.beat_req;
    assign beat.addr  = s_r.saddr;
    assign chain_busy = s_r.fetch.req;
    assign page_event = s_r.page_ev;
    assign done_event = s_r.done_ev;

    // checks on the block's outputs and its internal state
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic wr_lo3;
    logic wr_hi3;
    assign wr_lo3 = wr && apb_req.paddr == `DDS_OFF_DPTR_LO && apb_req.pstrb[3] && s_r.ch == CH_IDLE;
    assign wr_hi3 = wr && apb_req.paddr == `DDS_OFF_DPTR_HI && apb_req.pstrb[3] && s_r.ch == CH_IDLE;

    ptr_advance_a: assert property (fetch.req && fetch_ack |=> s_r.dptr == $past(s_r.dptr) +
        ($past(s_r.addr64) ? `DDS_STEP64 : `DDS_STEP32)) else $error("pointer did not advance");
    mask_low32_a: assert property (fetch.req && !s_r.addr64 |-> fetch.addr[1:0] == 2'b00)
        else $error("32-bit fetch address not aligned");
    mask_low64_a: assert property (fetch.req && s_r.addr64 |-> fetch.addr[2:0] == 3'b000)
        else $error("64-bit fetch address not aligned");
    start_byte7b_a: assert property (wr_lo3 && !s_r.addr64 |=> fetch.req && chain_busy)
        else $error("write to 07Bh did not start chain");
    start_byte7f_a: assert property (wr_hi3 && s_r.addr64 |=> fetch.req && chain_busy)
        else $error("write to 07Fh did not start chain");
    no_wrong_start_a: assert property (wr_lo3 && s_r.addr64 |=> !chain_busy)
        else $error("07Bh started chain in 64-bit mode");
    page_pause_a: assert property ($rose(page_event) |-> !beat.req && s_r.sd == SD_PAUSE)
        else $error("beats continued after page event");
    page_after_done_a: assert property ($rose(done_event) |-> ##1 !$rose(page_event))
        else $error("page event after transfer done");
    size_gate_a: assert property (s_r.sd == SD_IDLE && $past(s_r.sd) == SD_IDLE && $rose(done_event)
        |-> s_r.remain == 12'h000) else $error("transfer without data phase or size");
    apb_answer_a: assert property (acc_first |=> apb_rsp.pready ##1 !apb_rsp.pready)
        else $error("apb answer not one cycle");

    chain_run_c: cover property (fetch.req && fetch_ack && fetch_last);
    page_stop_c: cover property ($rose(page_event) ##[1:50] beat.req);
    single_done_c: cover property (beat.req && beat_ack ##1 $rose(done_event));
endmodule

// *** verification/dds_mem_model.sv ***
/*
 * system memory seen through the descriptor fetch and beat ports.
 * assumes: one clock shared with dds_top; acks are one-cycle pulses.
 */
`timescale 1ns/1ps
module dds_mem_model
(
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire dds_pkg::dds_fetch_s fetch,
    input  wire dds_pkg::dds_beat_s  beat,
    input  wire logic [3:0]          fetch_n,
    input  wire logic [3:0]          gap,
    output logic                     fetch_ack,
    output logic                     fetch_last,
    output logic                     beat_ack
);
    import dds_pkg::*;
    logic [3:0] f_done;
    logic [3:0] f_wait;
    logic [3:0] b_wait;
    // never acks twice in a row: the request may still stand one edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fetch_ack  <= 1'b0;
            fetch_last <= 1'b0;
            beat_ack   <= 1'b0;
            f_done     <= 4'h0;
            f_wait     <= 4'h0;
            b_wait     <= 4'h0;
        end
        else
        begin
            fetch_ack  <= 1'b0;
            fetch_last <= ~fetch_last;
            beat_ack   <= 1'b0;
            f_wait     <= fetch.req ? f_wait + 4'h1 : 4'h0;
            b_wait     <= beat.req ? b_wait + 4'h1 : 4'h0;
            if (!fetch.req)
                f_done <= 4'h0;
            if (fetch.req && !fetch_ack && f_wait >= gap)
            begin
                fetch_ack  <= 1'b1;
                fetch_last <= (f_done + 4'h1 == fetch_n);
                f_done     <= f_done + 4'h1;
                f_wait     <= 4'h0;
            end
            if (beat.req && !beat_ack && b_wait >= gap)
            begin
                beat_ack <= 1'b1;
                b_wait   <= 4'h0;
            end
        end
    end
endmodule

// *** verification/tb_dma_descriptor_and_block_setup.sv ***
/*
 * self-checking bench for dds_top: apb register access, chain fetch, beat dma.
 * assumes: dds_mem_model answers the memory ports.
 */
`timescale 1ns/1ps
module tb_dma_descriptor_and_block_setup;
    import dds_pkg::*;
    logic         pclk = 1'b0;
    logic         presetn = 1'b0;
    dds_apb_req_s req = '0;
    dds_apb_rsp_s rsp;
    dds_fetch_s   fetch;
    dds_beat_s    beat;
    logic         fetch_ack;
    logic         fetch_last;
    logic         beat_ack;
    logic         chain_busy;
    logic         page_event;
    logic         done_event;
    logic [3:0]   fetch_n = 4'h1;
    logic [3:0]   gap = 4'h0;
    logic [63:0]  exp_f = '0;
    logic [63:0]  step = '0;
    logic [31:0]  exp_b = '0;
    logic [31:0]  rdv;
    logic         erv;
    int           err_count = 0;
    int           total_checks = 0;
    int           f_count = 0;
    int           b_count = 0;

    dds_top dds_top_i (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .fetch(fetch),
        .fetch_ack(fetch_ack), .fetch_last(fetch_last), .beat(beat), .beat_ack(beat_ack),
        .chain_busy(chain_busy), .page_event(page_event), .done_event(done_event));
    dds_mem_model dds_mem_model_i (.pclk(pclk), .presetn(presetn), .fetch(fetch), .beat(beat),
        .fetch_n(fetch_n), .gap(gap), .fetch_ack(fetch_ack), .fetch_last(fetch_last), .beat_ack(beat_ack));

    always #20 pclk = ~pclk;

    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [63:0] g, input logic [63:0] e, input string m);
        total_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge pclk);
        req <= '{1'b1, 1'b0, w, a, d, s};
        @(posedge pclk);
        req.penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (rsp.pready !== 1'b1);
        chk(n, 2, "pready not after one wait state");
        rdv = rsp.prdata;
        erv = rsp.pslverr;
        req <= '0;
    endtask

    task automatic wait_sig(input logic on_done, input logic v);
        for (int i = 0; i < 200 && (on_done ? done_event : chain_busy) !== v; i++)
            @(negedge pclk);
    endtask

    // pointer, strobes and block-size readback
    task automatic t_regs();
        apb(1'b0, 8'h78, '0, 4'h0);
        chk(rdv, 32'h0000_0000, "ptr lo reset");
        apb(1'b0, 8'h40, '0, 4'h0);
        chk(erv, 1'b1, "unmapped no error");
        apb(1'b1, 8'h7C, 32'hA5A5_5A5A, 4'hF);
        apb(1'b1, 8'h78, 32'h1234_5678, 4'h7);
        apb(1'b0, 8'h78, '0, 4'h0);
        chk(rdv, 32'h0034_5678, "ptr lo");
        apb(1'b0, 8'h7C, '0, 4'h0);
        chk(rdv, 32'hA5A5_5A5A, "ptr hi");
        chk(chain_busy, 1'b0, "start without byte 3");
        apb(1'b1, 8'h80, 32'h0000_FFFF, 4'h3);
        apb(1'b0, 8'h80, '0, 4'h0);
        chk(rdv, 32'h0000_7FFF, "block size");
    endtask

    task automatic run_chain(input logic [7:0] a, input logic [31:0] d, input logic [63:0] e, input int n);
        exp_f = e;
        step = (a == 8'h78) ? 64'h0000_0000_0000_0004 : 64'h0000_0000_0000_0008;
        f_count = 0;
        fetch_n <= n[3:0];
        apb(1'b1, a, d, 4'hF);
        wait_sig(1'b0, 1'b1);
        chk(chain_busy, 1'b1, "chain not started");
        wait_sig(1'b0, 1'b0);
        chk(f_count, n, "fetch count");
    endtask

    // 32-bit then 64-bit chains, low pointer bits ignored
    task automatic t_chain();
        apb(1'b1, 8'h90, 32'h0000_0000, 4'h1);
        apb(1'b1, 8'h7C, 32'h0000_0000, 4'hF);
        gap <= 4'h0;
        run_chain(8'h78, 32'h1000_0003, 64'h0000_0000_1000_0000, 3);
        apb(1'b0, 8'h78, '0, 4'h0);
        chk(rdv & 32'hFFFF_FFFC, 32'h1000_000C, "ptr advance");
        apb(1'b1, 8'h90, 32'h0000_0001, 4'h1);
        apb(1'b1, 8'h78, 32'h2345_6787, 4'hF);
        repeat (4) @(negedge pclk);
        chk(chain_busy, 1'b0, "07Bh started 64-bit");
        gap <= 4'h2;
        run_chain(8'h7C, 32'h0000_0001, 64'h0000_0001_2345_6780, 2);
        apb(1'b1, 8'h90, 32'h0000_0000, 4'h1);
    endtask

    // page crossing, pause, resume and done
    task automatic single_page(input logic [2:0] c, input logic [31:0] sa, input logic [11:0] sz, input logic x);
        apb(1'b1, 8'h90, 32'h0000_0006, 4'h1);
        apb(1'b1, 8'h80, {17'h0, c, sz}, 4'h3);
        apb(1'b1, 8'h98, sa, 4'hF);
        exp_b = sa;
        b_count = 0;
        apb(1'b1, 8'h90, 32'h0000_0016, 4'h1);
        for (int i = 0; i < 200 && !(page_event || done_event); i++)
            @(negedge pclk);
        chk(page_event, x, "page event");
        if (x)
        begin
            repeat (4) @(negedge pclk);
            chk(beat.req, 1'b0, "no pause");
            apb(1'b1, 8'h94, 32'h0000_0008, 4'h1);
            apb(1'b1, 8'h98, exp_b, 4'hF);
            wait_sig(1'b1, 1'b1);
        end
        chk(done_event, 1'b1, "no done");
        chk(page_event, 1'b0, "page after done");
        chk(b_count, sz / 4, "beat count");
        apb(1'b1, 8'h94, 32'h0000_0018, 4'h1);
    endtask

    task automatic single_none(input logic [31:0] ctl, input logic [11:0] sz, input logic dn);
        apb(1'b1, 8'h80, {20'h0, sz}, 4'h3);
        b_count = 0;
        apb(1'b1, 8'h90, ctl, 4'h1);
        apb(1'b1, 8'h90, ctl | 32'h0000_0010, 4'h1);
        repeat (6) @(negedge pclk);
        chk(done_event, dn, "done event");
        chk(b_count, 0, "beats moved");
        apb(1'b1, 8'h94, 32'h0000_0018, 4'h1);
    endtask

    always @(posedge pclk)
    begin
        if (presetn && fetch.req && fetch_ack)
        begin
            chk(fetch.addr, exp_f, "fetch address");
            exp_f = exp_f + step;
            f_count++;
        end
        if (presetn && beat.req && beat_ack)
        begin
            chk(beat.addr, exp_b, "beat address");
            exp_b = exp_b + 32'h0000_0004;
            b_count++;
        end
    end

    initial
    begin
        repeat (20000) @(posedge pclk);
        err_count++;
        $display("[FAIL] %0t watchdog", $time);
        wrap_up();
    end

    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_chain();
        gap <= 4'h1;
        single_page(3'h0, 32'h0000_0FF8, 12'h010, 1'b1);
        single_page(3'h7, 32'h0007_FFFC, 12'h008, 1'b1);
        single_page(3'h1, 32'h0000_0FF8, 12'h010, 1'b0);
        single_none(32'h0000_0006, 12'h000, 1'b1);
        single_none(32'h0000_0002, 12'h010, 1'b1);
        single_none(32'h0000_0004, 12'h010, 1'b0);
        wrap_up();
    end
endmodule
